// *** pkg/nvi_pkg.sv ***
/*
 * Shared constants and types for the two-wire nonvolatile RAM slave:
 * array geometry, bit counts, bus timing figures, pin and state carriers.
 * Assumes a 100 MHz system clock and a bus master that owns the clock line.
 */
package nvi_pkg;

    // Array geometry: 32768 bytes behind a 15-bit address
    localparam int MEM_DEPTH = 32768;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam logic [14:0] ADDR_LAST = 15'h7fff;
    localparam logic [14:0] ADDR_STEP = 15'h0001;

    // Bits of one byte on the wire; ack follows the eighth
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_RST = 4'h0;

    // Index of the top data bit, shifted first
    localparam int MSB = 7;

    // Timing: system clock and fastest serial clock, in kHz
    localparam int CLK_FREQ_KHZ = 100000;
    localparam int SCL_MAX_KHZ = 1000;
    // Least half period of the serial clock, rounded up to cycles
    localparam int SCL_HALF_MIN_CYC =
        (CLK_FREQ_KHZ + 2 * SCL_MAX_KHZ - 1) / (2 * SCL_MAX_KHZ);

    // Depth of the write buffer between the bus and the array
    localparam int WBUF_DEPTH = 2;
    localparam logic [1:0] WBUF_FULL = 2'h2;

    // Pins after synchronisation, as one vector
    typedef struct packed {
        logic [2:0] sel;
        logic wp;
        logic sda;
        logic scl;
    } nvi_pins_s;

    // One pending array write
    typedef struct packed {
        logic [14:0] addr;
        logic [7:0] data;
    } nvi_wr_s;

    // Protocol phase
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVADR,
        ST_MEMHI,
        ST_MEMLO,
        ST_WRDATA,
        ST_RDDATA,
        ST_RDACK
    } nvi_phase_e;

    // Whole state of the slave
    typedef struct packed {
        nvi_pins_s s1;
        nvi_pins_s s2;
        nvi_pins_s s3;
        nvi_pins_s flt;
        nvi_pins_s fltq;
        nvi_phase_e phase;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [14:0] addr;
        logic ack_ph;
        logic macked;
        logic oe;
        logic drv;
        nvi_wr_s wb0;
        nvi_wr_s wb1;
        logic wb_head;
        logic [1:0] wb_cnt;
    } nvi_state_s;

    localparam nvi_state_s STATE_RST = '0;

endpackage

// *** logic/nvi_mem.sv ***
/*
 * Byte array of the nonvolatile RAM: one write port, one read port,
 * one access per cycle, read wins. Read data come out of a register.
 * Assumes the caller holds a write until wr_rdy is high.
 */
`timescale 1ns/10ps
`default_nettype none

module nvi_mem #(
    parameter int AW = nvi_pkg::ADDR_W,
    parameter int DW = nvi_pkg::DATA_W,
    parameter int DEPTH = nvi_pkg::MEM_DEPTH
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    output logic wr_rdy,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem [DEPTH];

    // A read takes the cycle; the write waits one cycle
    assign wr_rdy = !rd_en;

    // Array has no reset: contents are meant to survive
    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end else if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

endmodule

`default_nettype wire

// *** logic/nvi_slave.sv ***
/*
 * Two-wire serial slave in front of a 32K x 8 nonvolatile array.
 * Holds pin synchronisers, edge detection, the protocol machine, a
 * two-entry write buffer and the array instance.
 * Assumes an open-drain bus resolved outside, with pull-ups on the lines
 * and pull-downs on the select and protect pins.
 */
// Notes on behaviour
// R1: The array holds 32768 bytes reached one byte at a time.
// R2: A received data byte goes to the array as soon as it is complete.
// R3: The slave is ready for a new transaction right after a write.
// R4: The slave answers only when the select bits match its select pins.
// R5: Open select pins read as low thanks to pull-downs.
// R6: The data line is only pulled low or released, never driven high.
// R7: Output bits change after the clock falls; inputs are taken as it rises.
// R8: No location is written while the protect pin is high.
// R9: All locations may be written while the protect pin is low.
// R10: An open protect pin reads low, so the array is writable by default.
// R11: Serial clock runs up to 1 MHz, and 100 kHz and 400 kHz also work.
// R12: Slave address is type in bits 7-4, select in 3-1, read flag in bit 0.
// R13: Two address bytes keep 15 bits; the address steps per byte and wraps.
// R14: The receiver pulls data low after the eighth bit; no ack ends it.
// R15: Every byte is shifted most significant bit first.
// R16: Protected data bytes are still acknowledged and step the address.
// R17: Clock and data are synchronised and their edges found before use.
`timescale 1ns/10ps
`default_nettype none

module nvi_slave #(
    // Device type code; value is arbitrary
    parameter logic [3:0] DEV_TYPE = 4'h5
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic [2:0] DEV_SELECT_PINS,
    input wire logic WP
);

    nvi_pkg::nvi_state_s r_reg;
    nvi_pkg::nvi_state_s r_next;
    nvi_pkg::nvi_pins_s pins_in;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic sel_match;
    logic push;
    logic inc;
    logic rd_en;
    logic [14:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_rdy;
    logic wr_en;
    logic pop;
    nvi_pkg::nvi_wr_s wr_head;

    // Pins gathered into one vector for the synchroniser
    always_comb begin
        pins_in.sel = DEV_SELECT_PINS; // R5
        pins_in.wp = WP; // R10
        pins_in.sda = SDA_IN;
        pins_in.scl = SCL;
    end

    // Edges and bus conditions seen on the filtered levels
    assign scl_rise = r_reg.flt.scl && !r_reg.fltq.scl; // R17
    assign scl_fall = !r_reg.flt.scl && r_reg.fltq.scl; // R17
    // Both lines pass the same filter, so no skew fakes a start
    assign start_c = r_reg.flt.scl && r_reg.fltq.scl && !r_reg.flt.sda &&
                     r_reg.fltq.sda;
    assign stop_c = r_reg.flt.scl && r_reg.fltq.scl && r_reg.flt.sda &&
                    !r_reg.fltq.sda;
    assign sel_match = (r_reg.shreg[7:4] == DEV_TYPE) &&
                       (r_reg.shreg[3:1] == r_reg.flt.sel); // R4 R12

    // Buffer head toward the array
    assign wr_head = r_reg.wb_head ? r_reg.wb1 : r_reg.wb0;
    assign wr_en = (r_reg.wb_cnt != 2'h0);
    assign pop = wr_en && wr_rdy;

    nvi_mem #(
        .AW(nvi_pkg::ADDR_W),
        .DW(nvi_pkg::DATA_W),
        .DEPTH(nvi_pkg::MEM_DEPTH)
    ) nvi_mem_i (
        .clk(CLK),
        .wr_en(wr_en),
        .wr_addr(wr_head.addr),
        .wr_data(wr_head.data),
        .wr_rdy(wr_rdy),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    ); // R1

    // Next state of the whole slave
    always_comb begin
        r_next = r_reg;
        push = 1'b0;
        inc = 1'b0;
        rd_en = 1'b0;
        rd_addr = r_reg.addr;
        r_next.drv = 1'b0; // R6
        // Three stages; a level is taken once stages two and three agree
        // Four cycles of lag fit well inside the shortest 1 MHz half period
        r_next.s1 = pins_in;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.flt = nvi_pkg::nvi_pins_s'(((r_reg.s2 ~^ r_reg.s3) & r_reg.s2) |
                     ((r_reg.s2 ^ r_reg.s3) & r_reg.flt)); // R17 R11
        r_next.fltq = r_reg.flt;
        if (start_c) begin
            // A start aborts anything and waits for an address
            r_next.phase = nvi_pkg::ST_DEVADR;
            r_next.cnt = nvi_pkg::CNT_RST;
            r_next.ack_ph = 1'b0;
            r_next.oe = 1'b0;
        end else if (stop_c) begin
            r_next.phase = nvi_pkg::ST_IDLE; // R3
            r_next.ack_ph = 1'b0;
            r_next.oe = 1'b0;
        end else if (r_reg.phase != nvi_pkg::ST_IDLE) begin
            if (scl_rise) begin
                if (r_reg.phase == nvi_pkg::ST_RDACK) begin
                    r_next.macked = !r_reg.flt.sda; // R14
                end else if (!r_reg.ack_ph &&
                             r_reg.cnt != nvi_pkg::BYTE_BITS) begin
                    r_next.cnt = r_reg.cnt + 4'h1; // R7
                    if (r_reg.phase != nvi_pkg::ST_RDDATA) begin
                        r_next.shreg = {r_reg.shreg[6:0], r_reg.flt.sda}; // R15
                    end
                end
            end else if (scl_fall) begin
                if (r_reg.ack_ph) begin
                    // Ack clock over: release, or start a read byte
                    r_next.ack_ph = 1'b0;
                    r_next.cnt = nvi_pkg::CNT_RST;
                    r_next.oe = 1'b0;
                    if (r_reg.phase == nvi_pkg::ST_RDDATA) begin
                        r_next.shreg = rd_data;
                        r_next.oe = !rd_data[nvi_pkg::MSB]; // R6 R15
                    end
                end else if (r_reg.phase == nvi_pkg::ST_RDACK) begin
                    r_next.cnt = nvi_pkg::CNT_RST;
                    if (r_reg.macked) begin
                        r_next.phase = nvi_pkg::ST_RDDATA;
                        r_next.shreg = rd_data;
                        r_next.oe = !rd_data[nvi_pkg::MSB]; // R7
                    end else begin
                        r_next.phase = nvi_pkg::ST_IDLE; // R14
                    end
                end else if (r_reg.phase == nvi_pkg::ST_RDDATA) begin
                    if (r_reg.cnt == nvi_pkg::BYTE_BITS) begin
                        // Byte out; step address and fetch the next one
                        r_next.oe = 1'b0;
                        r_next.macked = 1'b0;
                        r_next.phase = nvi_pkg::ST_RDACK;
                        inc = 1'b1; // R13
                        rd_en = 1'b1;
                        rd_addr = r_reg.addr + nvi_pkg::ADDR_STEP;
                    end else if (r_reg.cnt != nvi_pkg::CNT_RST) begin
                        r_next.shreg = {r_reg.shreg[6:0], 1'b0};
                        r_next.oe = !r_reg.shreg[6]; // R7 R15
                    end
                end else if (r_reg.cnt == nvi_pkg::BYTE_BITS) begin
                    // Eighth bit in: decide the ack and act on the byte
                    r_next.ack_ph = 1'b1;
                    r_next.oe = 1'b1; // R14
                    unique case (r_reg.phase)
                        nvi_pkg::ST_DEVADR: begin
                            if (!sel_match) begin
                                r_next.phase = nvi_pkg::ST_IDLE; // R4
                                r_next.ack_ph = 1'b0;
                                r_next.oe = 1'b0;
                            end else if (r_reg.shreg[0]) begin
                                r_next.phase = nvi_pkg::ST_RDDATA; // R12
                                rd_en = 1'b1;
                            end else begin
                                r_next.phase = nvi_pkg::ST_MEMHI;
                            end
                        end
                        nvi_pkg::ST_MEMHI: begin
                            // Top address bit is dropped
                            r_next.addr[14:8] = r_reg.shreg[6:0]; // R13
                            r_next.phase = nvi_pkg::ST_MEMLO;
                        end
                        nvi_pkg::ST_MEMLO: begin
                            r_next.addr[7:0] = r_reg.shreg;
                            r_next.phase = nvi_pkg::ST_WRDATA;
                        end
                        nvi_pkg::ST_WRDATA: begin
                            if (r_reg.wb_cnt == nvi_pkg::WBUF_FULL) begin
                                // No room: refuse rather than lose it
                                r_next.phase = nvi_pkg::ST_IDLE;
                                r_next.ack_ph = 1'b0;
                                r_next.oe = 1'b0;
                            end else begin
                                push = !r_reg.flt.wp; // R8 R9 R2
                                inc = 1'b1; // R16
                            end
                        end
                        default: begin
                            r_next.phase = nvi_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
        end
        if (inc) begin
            r_next.addr = r_reg.addr + nvi_pkg::ADDR_STEP; // R13
        end
        // Two-entry write buffer; a push lands behind what is queued
        if (push) begin
            if (r_reg.wb_head ^ r_reg.wb_cnt[0]) begin
                r_next.wb1 = '{addr: r_reg.addr, data: r_reg.shreg};
            end else begin
                r_next.wb0 = '{addr: r_reg.addr, data: r_reg.shreg};
            end
        end
        if (pop) begin
            r_next.wb_head = !r_reg.wb_head;
        end
        r_next.wb_cnt = r_reg.wb_cnt + {1'b0, push} - {1'b0, pop};
    end

    // Single register of the whole state
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            r_reg <= nvi_pkg::STATE_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign SDA_OUT = r_reg.drv;
    assign SDA_OE = r_reg.oe;

    property p_low_only;
        @(posedge CLK) disable iff (SYS_RST)
        SDA_OE |-> (SDA_OUT == 1'b0);
    endproperty
    a_low_only: assert property (p_low_only) // R6
        else $error("data line driven high");

    property p_drive_after_fall;
        @(posedge CLK) disable iff (SYS_RST)
        $rose(SDA_OE) |-> $past(scl_fall);
    endproperty
    a_drive_after_fall: assert property (p_drive_after_fall) // R7
        else $error("drive began away from a falling clock");

    property p_count_on_rise;
        @(posedge CLK) disable iff (SYS_RST)
        (r_reg.cnt != $past(r_reg.cnt) && r_reg.cnt != 4'h0) |->
            $past(scl_rise);
    endproperty
    a_count_on_rise: assert property (p_count_on_rise) // R7
        else $error("bit counted away from a rising clock");

    property p_protect;
        @(posedge CLK) disable iff (SYS_RST)
        r_reg.flt.wp |-> !push;
    endproperty
    a_protect: assert property (p_protect) // R8
        else $error("write queued while protected");

    property p_commit;
        @(posedge CLK) disable iff (SYS_RST)
        push |=> ##[0:3] (wr_en && wr_rdy);
    endproperty
    a_commit: assert property (p_commit) // R2
        else $error("queued byte not written in time");

    property p_select;
        @(posedge CLK) disable iff (SYS_RST)
        (r_reg.phase == nvi_pkg::ST_DEVADR && scl_fall && !r_reg.ack_ph &&
         r_reg.cnt == nvi_pkg::BYTE_BITS) |=> (SDA_OE == $past(sel_match));
    endproperty
    a_select: assert property (p_select) // R4
        else $error("address ack does not follow select match");

    property p_step;
        @(posedge CLK) disable iff (SYS_RST)
        inc |=> (r_reg.addr == 15'($past(r_reg.addr) + 15'h0001));
    endproperty
    a_step: assert property (p_step) // R13
        else $error("address did not step by one");

    property p_wrap;
        @(posedge CLK) disable iff (SYS_RST)
        (inc && r_reg.addr == nvi_pkg::ADDR_LAST) |=> (r_reg.addr == 15'h0000);
    endproperty
    a_wrap: assert property (p_wrap) // R13
        else $error("address did not wrap to zero");

    property p_protected_ack;
        @(posedge CLK) disable iff (SYS_RST)
        (r_reg.phase == nvi_pkg::ST_WRDATA && scl_fall && !r_reg.ack_ph &&
         r_reg.cnt == nvi_pkg::BYTE_BITS && r_reg.flt.wp && !start_c &&
         !stop_c && r_reg.wb_cnt != nvi_pkg::WBUF_FULL) |=>
            SDA_OE && (r_reg.addr == 15'($past(r_reg.addr) + 15'h0001));
    endproperty
    a_protected_ack: assert property (p_protected_ack) // R16
        else $error("protected byte not acknowledged");

    property p_stop_idle;
        @(posedge CLK) disable iff (SYS_RST)
        stop_c |=> (r_reg.phase == nvi_pkg::ST_IDLE) && !SDA_OE;
    endproperty
    a_stop_idle: assert property (p_stop_idle) // R3
        else $error("slave not idle after stop");

endmodule

`default_nettype wire

// *** testbench/nvi_master.sv ***
/*
 * Behavioural two-wire bus master that drives the slave under test:
 * START, STOP, byte writes and reads with acknowledge, settable bit rate.
 * Assumes the bench resolves the data wire with a pull-up and feeds it back.
 */
`timescale 1ns/10ps
`default_nettype none

module nvi_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // Half period of the serial clock in system cycles; 8 gives 80 ns
    int half = 8;

    // Idle bus: clock stands high, data left to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // All changes land just after a system clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Data set mid low phase, held through the high phase
    task automatic bit_out(input logic b);
        tick(half / 2);
        sda_low = ~b;
        tick(half - half / 2);
        scl = 1'b1;
        tick(half);
        scl = 1'b0;
    endtask

    // Released line, sampled in the middle of the high phase
    task automatic bit_in(output logic b);
        tick(half / 2);
        sda_low = 1'b0;
        tick(half - half / 2);
        scl = 1'b1;
        tick(half / 2);
        b = sda;
        tick(half - half / 2);
        scl = 1'b0;
    endtask

    // Also serves as repeated START when the clock is low
    task automatic start();
        if (scl == 1'b0) begin
            tick(half / 2);
            sda_low = 1'b0;
            tick(half - half / 2);
            scl = 1'b1;
        end
        tick(half);
        sda_low = 1'b1;
        tick(half);
        scl = 1'b0;
    endtask

    // Data rises while the clock is high, then the bus idles
    task automatic stop();
        tick(half / 2);
        sda_low = 1'b1;
        tick(half - half / 2);
        scl = 1'b1;
        tick(half);
        sda_low = 1'b0;
        tick(half);
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(b);
        ack = ~b;
    endtask

    task automatic read_byte(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(~more);
    endtask
endmodule
`default_nettype wire

// *** testbench/nvi_slave_tb.sv ***
/*
 * Self-checking bench for the two-wire slave: select matching, write,
 * wrap, write protect, master NACK and bit rates, through a master model.
 * Assumes the design's default synchronisers and a 100 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

module nvi_slave_tb;
    // Type nibble; value is arbitrary
    localparam logic [3:0] TYPE = 4'h5;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic scl, sda_low, sda_out, sda_oe, sda, prev_oe;
    logic [2:0] sel_drv = 3'h0;
    logic sel_en = 1'b1;
    logic wp_drv = 1'b0;
    logic wp_en = 1'b1;
    tri0 [2:0] sel_pin;
    tri0 wp_pin;
    int n_fail = 0;
    int compares = 0;

    // Pins left open fall to their pull-downs
    assign sel_pin = sel_en ? sel_drv : 3'hz;
    assign wp_pin = wp_en ? wp_drv : 1'hz;
    // Wired-AND data line with a pull-up
    assign sda = ~(sda_low | sda_oe);

    always #5 clk = ~clk;

    nvi_slave #(.DEV_TYPE(TYPE)) nvi_slave_i (
        .CLK(clk), .SYS_RST(sys_rst), .SCL(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .DEV_SELECT_PINS(sel_pin), .WP(wp_pin)
    );

    nvi_master nvi_master_i (
        .clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low)
    );

    // Wire checks every cycle: never high, moves only with clock low
    always @(posedge clk) begin
        if (sda_oe === 1'b1 && sda_out !== 1'b0) begin
            n_fail++;
            $display("[FAIL] drive level expected 0 seen %b", sda_out);
        end
        if (!sys_rst && sda_oe !== prev_oe && scl !== 1'b0) begin
            n_fail++;
            $display("[FAIL] oe change expected scl 0 seen %b", scl);
        end
        prev_oe <= sda_oe;
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] adr(input logic [2:0] s, input logic r);
        return {TYPE, s, r};
    endfunction

    task automatic put(input logic [7:0] d, input logic exp);
        logic a;
        nvi_master_i.write_byte(d, a);
        chk("ack", {7'h0, exp}, {7'h0, a});
    endtask

    task automatic get(input logic more, input logic [7:0] exp);
        logic [7:0] d;
        nvi_master_i.read_byte(more, d);
        chk("read data", exp, d);
    endtask

    // Opens a write and loads the address latch
    task automatic seta(input logic [15:0] a);
        nvi_master_i.start();
        put(adr(sel_drv, 1'b0), 1'b1);
        put(a[15:8], 1'b1);
        put(a[7:0], 1'b1);
    endtask

    task automatic rd_cur();
        nvi_master_i.start();
        put(adr(sel_drv, 1'b1), 1'b1);
    endtask

    // Each select value: own address acks, neighbour and wrong type do not
    task automatic t_select();
        for (int s = 0; s < 8; s++) begin
            sel_drv = s[2:0];
            nvi_master_i.start();
            put(adr(sel_drv, 1'b0), 1'b1);
            nvi_master_i.start();
            put(adr(sel_drv ^ 3'h1, 1'b0), 1'b0);
            nvi_master_i.start();
            put({TYPE ^ 4'h1, sel_drv, 1'b0}, 1'b0);
            nvi_master_i.stop();
        end
        sel_en = 1'b0;
        nvi_master_i.start();
        put(adr(3'h0, 1'b0), 1'b1);
        nvi_master_i.stop();
        sel_drv = 3'h0;
    endtask

    // Top address bit ignored, wrap to zero, readback right after STOP
    task automatic t_wrap();
        wp_en = 1'b0;
        seta(16'hffff);
        put(8'ha5, 1'b1);
        put(8'h3c, 1'b1);
        put(8'h96, 1'b1);
        nvi_master_i.stop();
        seta(16'h7fff);
        rd_cur();
        get(1'b1, 8'ha5);
        get(1'b1, 8'h3c);
        get(1'b0, 8'h96);
        nvi_master_i.stop();
        chk("oe after nack", 8'h0, {7'h0, sda_oe});
        wp_en = 1'b1;
    endtask

    // Protected byte is acked and steps the latch but is not stored
    task automatic t_protect();
        seta(16'h0100);
        put(8'h77, 1'b1);
        put(8'h88, 1'b1);
        nvi_master_i.stop();
        wp_drv = 1'b1;
        seta(16'h0100);
        put(8'h11, 1'b1);
        nvi_master_i.stop();
        rd_cur();
        get(1'b0, 8'h88);
        nvi_master_i.stop();
        wp_drv = 1'b0;
        seta(16'h0100);
        rd_cur();
        get(1'b1, 8'h77);
        get(1'b0, 8'h88);
        nvi_master_i.stop();
    endtask

    // 100 kHz probe, then 400 kHz and 1 MHz round trips
    task automatic t_rate();
        int h[3] = '{500, 125, 50};
        for (int i = 0; i < 3; i++) begin
            nvi_master_i.half = h[i];
            if (h[i] > 200) begin
                nvi_master_i.start();
                put(adr(sel_drv, 1'b0), 1'b1);
            end else begin
                seta(16'h0200);
                put(h[i][7:0], 1'b1);
                seta(16'h0200);
                rd_cur();
                get(1'b0, h[i][7:0]);
            end
            nvi_master_i.stop();
        end
        nvi_master_i.half = 8;
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard, about twice the expected run
    initial begin
        #1000000;
        n_fail++;
        wrap_up();
    end

    // Main sequence
    initial begin
        prev_oe = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        t_select();
        t_wrap();
        t_protect();
        t_rate();
        wrap_up();
    end
endmodule
`default_nettype wire
